// ===== inc/tpi_pkg.sv
// constants and carriers for the timer pin initialization block
// Summary of operation
// R1 - io control write in normal, pwm one, pwm two or phase mode drives selected initial levels
// R2 - pwm mode one leaves b and d side pins alone on io write
// R3 - pwm mode two leaves the cycle register pin alone on io write
// R4 - normal or pwm two: buffering c or d blocks init of that pin
// R5 - pwm mode one: any c or d buffering blocks init of the c pin
// R6 - software clears buffering, initializes, then restores buffering
// R7 - before complementary or reset-sync pwm, software initializes in normal mode
// R8 - software writes level control, then mode, then master enable
// R9 - after reset outputs are low and mode is normal
// R10 - software enables channel 3 and 4 output before io init
// R11 - compare match with low action drives the pin low
// R12 - on error software hands pins to ports, then stops counting
// R13 - recovery: set mode, init via io, return pins, restart counting
// R14 - pwm mode two exists on channels 0 to 2 only
// R15 - phase counting exists on channels 1 and 2 only
// R16 - normal to complementary: init, disable io section, outputs off, program, enable
// R17 - pwm one to complementary: go normal first, then init and disable
// R18 - reset-sync pwm: level, mode, enable outputs, pins back, restart
// R19 - io write applies initial level at once, without a compare match
package tpi_pkg;
  localparam int NCH  = 5;
  localparam int NPIN = 4;
  localparam int NMOE = 2;
  localparam int MOE_FIRST_CH = 3;
  localparam int PWM_MODE_TWO_LAST_CH = 2;
  localparam int PHASE_FIRST_CH = 1;
  localparam int PHASE_LAST_CH  = 2;
  localparam int PIN_C = 2;
  localparam int PIN_D = 3;
  // mode codes
  localparam logic [2:0] MD_NORMAL = 3'h0;
  localparam logic [2:0] MD_PWM_MODE_ONE   = 3'h2;
  localparam logic [2:0] MD_PWM_MODE_TWO   = 3'h3;
  localparam logic [2:0] MD_PHASE  = 3'h4;
  localparam logic [2:0] MD_COMPLEMENTARY_PWM_MODE   = 3'h5;
  localparam logic [2:0] MD_RESET_SYNC_PWM_MODE   = 3'h6;
  // compare actions
  localparam logic [1:0] ACT_HOLD   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  // register map
  localparam logic [7:0] OFS_MODE  = 8'h00;
  localparam logic [7:0] OFS_IO    = 8'h04;
  localparam logic [7:0] OFS_START = 8'h50;
  localparam logic [7:0] OFS_MOE   = 8'h54;
  localparam logic [7:0] OFS_OLC   = 8'h58;
  localparam logic [7:0] OFS_PINS  = 8'h5c;
  localparam int CH_SHIFT = 4;
  localparam logic [3:0] CH_SUB_MASK = 4'hf;
  localparam logic [7:0] OLC_RST = 8'h00;
  typedef struct packed {
    logic [1:0] cyc_sel;
    logic       buf_d;
    logic       buf_c;
    logic [2:0] mode;
  } tpi_mode_t;
  typedef struct packed {
    logic [1:0] act;
    logic       init_hi;
    logic       out_en;
  } tpi_pin_io_t;
  typedef tpi_pin_io_t [NPIN-1:0] tpi_io_t;
  localparam tpi_mode_t MODE_RST = '{cyc_sel: 2'h0, buf_d: 1'b0, buf_c: 1'b0, mode: MD_NORMAL};
  localparam tpi_io_t   IO_RST   = '0;
endpackage

// ===== rtl/tpi_pin_unit.sv
// per-channel next pin level: io-write initialization and compare actions
`timescale 1ns/1ps
`default_nettype none
module tpi_pin_unit (
  // channel setup
  input  wire tpi_pkg::tpi_mode_t mode_i,
  input  wire tpi_pkg::tpi_io_t   io_i,
  input  wire logic               io_wr_i,
  input  wire logic               gate_i,
  // counting
  input  wire logic               run_i,
  input  wire logic [3:0]         match_i,
  // levels
  input  wire logic [3:0]         lvl_i,
  output logic      [3:0]         next_lvl_o
);
  logic init_mode;
  logic pwm_mode_one;
  logic pwm_mode_two;
  logic [3:0] blocked;

  always_comb begin
    pwm_mode_one = (mode_i.mode == tpi_pkg::MD_PWM_MODE_ONE);
    pwm_mode_two = (mode_i.mode == tpi_pkg::MD_PWM_MODE_TWO);
    // R1 io-controlled modes
    init_mode = (mode_i.mode == tpi_pkg::MD_NORMAL) || pwm_mode_one || pwm_mode_two ||
                (mode_i.mode == tpi_pkg::MD_PHASE);
    blocked = 4'h0;
    for (int p = 0; p < tpi_pkg::NPIN; p++) begin
      // R2 b and d sides idle
      if (pwm_mode_one && p[0]) begin
        blocked[p] = 1'b1;
      end
      // R3 cycle register pin
      if (pwm_mode_two && (p[1:0] == mode_i.cyc_sel)) begin
        blocked[p] = 1'b1;
      end
    end
    // R4 buffer pins in normal or pwm two
    if (!pwm_mode_one) begin
      blocked[tpi_pkg::PIN_C] = blocked[tpi_pkg::PIN_C] | mode_i.buf_c;
      blocked[tpi_pkg::PIN_D] = blocked[tpi_pkg::PIN_D] | mode_i.buf_d;
    end else begin
      // R5 either buffer blocks c
      blocked[tpi_pkg::PIN_C] = blocked[tpi_pkg::PIN_C] | mode_i.buf_c | mode_i.buf_d;
    end
    next_lvl_o = lvl_i;
    for (int p = 0; p < tpi_pkg::NPIN; p++) begin
      if (gate_i && init_mode && io_i[p].out_en) begin
        if (io_wr_i) begin
          // R19 immediate initial level
          if (!blocked[p]) begin
            next_lvl_o[p] = io_i[p].init_hi;
          end
        end else if (run_i && match_i[p] && !(pwm_mode_one && p[0])) begin
          // R11 compare action
          unique case (io_i[p].act)
            tpi_pkg::ACT_HOLD:   next_lvl_o[p] = lvl_i[p];
            tpi_pkg::ACT_LOW:    next_lvl_o[p] = 1'b0;
            tpi_pkg::ACT_HIGH:   next_lvl_o[p] = 1'b1;
            tpi_pkg::ACT_TOGGLE: next_lvl_o[p] = ~lvl_i[p];
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/tpi_top.sv
// timer pin initialization and mode control with wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module tpi_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // compare events, one pulse per pin, pin index ch*4+p
  input  wire logic [19:0] match_i,
  // timer pins toward the pin function controller
  output logic      [19:0] pin_lvl_o,
  output logic      [19:0] pin_drv_o,
  output logic      [4:0]  run_o
);
  typedef struct packed {
    logic                                    ack;
    logic [31:0]                             dat;
    tpi_pkg::tpi_mode_t [tpi_pkg::NCH-1:0]   mode;
    tpi_pkg::tpi_io_t   [tpi_pkg::NCH-1:0]   io;
    logic [tpi_pkg::NCH-1:0]                 start;
    logic [tpi_pkg::NMOE-1:0]                moe;
    logic [7:0]                              olc;
    logic [19:0]                             lvl;
    logic [19:0]                             drv;
  } tpi_state_t;

  tpi_state_t st;
  tpi_state_t next_st;
  logic       req;
  logic       wr;
  logic [2:0] ch;
  logic [3:0] sub;
  logic [tpi_pkg::NCH-1:0] io_wr;
  logic [tpi_pkg::NCH-1:0] gate;
  logic [19:0] next_lvl;

  // byte-lane merge of write data
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // channel limits of the special modes
  function automatic logic mode_ok(input int c, input logic [2:0] m);
    logic ok;
    ok = 1'b1;
    // R14 pwm two channels
    if (m == tpi_pkg::MD_PWM_MODE_TWO) begin
      ok = (c <= tpi_pkg::PWM_MODE_TWO_LAST_CH);
    end
    // R15 phase counting channels
    if (m == tpi_pkg::MD_PHASE) begin
      ok = (c >= tpi_pkg::PHASE_FIRST_CH) && (c <= tpi_pkg::PHASE_LAST_CH);
    end
    return ok;
  endfunction

  // output master enable only covers the upper channels
  function automatic logic gated(input int c, input logic [tpi_pkg::NMOE-1:0] moe);
    logic g;
    g = 1'b1;
    if (c >= tpi_pkg::MOE_FIRST_CH) begin
      g = moe[c - tpi_pkg::MOE_FIRST_CH];
    end
    return g;
  endfunction

  // slot decode inside one channel window, shared by the strobe and the register mux
  function automatic logic slot_hit(input logic [3:0] s, input logic [7:0] ofs);
    return {4'h0, s} == ofs;
  endfunction

  always_comb begin
    req = cyc_i && stb_i && !st.ack;
    wr  = req && we_i;
    ch  = adr_i[6:4];
    sub = adr_i[3:0] & tpi_pkg::CH_SUB_MASK;
    for (int c = 0; c < tpi_pkg::NCH; c++) begin
      io_wr[c] = wr && (ch == 3'(c)) && (adr_i < tpi_pkg::OFS_START) &&
                 slot_hit(sub, tpi_pkg::OFS_IO);
      // R10 upper channels need master enable
      gate[c] = gated(c, st.moe);
    end
  end

  for (genvar g = 0; g < tpi_pkg::NCH; g++) begin : g_ch
    tpi_pin_unit u_pin (
      .mode_i     (st.mode[g]),
      .io_i       (io_wr[g] ? tpi_pkg::tpi_io_t'(merge({16'h0, st.io[g]}, dat_i, sel_i)) :
                              st.io[g]),
      .io_wr_i    (io_wr[g]),
      .gate_i     (gate[g]),
      .run_i      (st.start[g]),
      .match_i    (match_i[g*4 +: 4]),
      .lvl_i      (st.lvl[g*4 +: 4]),
      .next_lvl_o (next_lvl[g*4 +: 4])
    );
  end

  always_comb begin
    logic [31:0] rd;
    logic [31:0] mw;
    rd = 32'h0;
    mw = 32'h0;
    next_st = st;
    next_st.ack = req;
    next_st.lvl = next_lvl;
    if (adr_i < tpi_pkg::OFS_START) begin
      if (ch < 3'(tpi_pkg::NCH)) begin
        if (slot_hit(sub, tpi_pkg::OFS_MODE)) begin
          rd = {25'h0, st.mode[ch]};
          mw = merge(rd, dat_i, sel_i);
          if (wr && mode_ok(int'(ch), mw[2:0])) begin
            next_st.mode[ch] = tpi_pkg::tpi_mode_t'(mw[6:0]);
          end
        end else if (slot_hit(sub, tpi_pkg::OFS_IO)) begin
          rd = {16'h0, st.io[ch]};
          mw = merge(rd, dat_i, sel_i);
          if (wr) begin
            next_st.io[ch] = tpi_pkg::tpi_io_t'(mw[15:0]);
          end
        end
      end
    end else begin
      unique case (adr_i)
        tpi_pkg::OFS_START: begin
          rd = {27'h0, st.start};
          mw = merge(rd, dat_i, sel_i);
          if (wr) begin
            next_st.start = mw[4:0];
          end
        end
        tpi_pkg::OFS_MOE: begin
          rd = {30'h0, st.moe};
          mw = merge(rd, dat_i, sel_i);
          if (wr) begin
            next_st.moe = mw[1:0];
          end
        end
        tpi_pkg::OFS_OLC: begin
          rd = {24'h0, st.olc};
          mw = merge(rd, dat_i, sel_i);
          if (wr) begin
            next_st.olc = mw[7:0];
          end
        end
        tpi_pkg::OFS_PINS: rd = {12'h0, st.lvl};
        default: rd = 32'h0;
      endcase
    end
    next_st.dat = req ? rd : st.dat;
    // drive enable follows io setup and master enable
    for (int c = 0; c < tpi_pkg::NCH; c++) begin
      for (int p = 0; p < tpi_pkg::NPIN; p++) begin
        next_st.drv[c*4+p] = next_st.io[c][p].out_en && gated(c, next_st.moe);
      end
    end
  end

  // R9 outputs low, normal mode at reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st.ack   <= 1'b0;
      st.dat   <= 32'h0;
      st.mode  <= {tpi_pkg::NCH{tpi_pkg::MODE_RST}};
      st.io    <= {tpi_pkg::NCH{tpi_pkg::IO_RST}};
      st.start <= 5'h0;
      st.moe   <= 2'h0;
      st.olc   <= tpi_pkg::OLC_RST;
      st.lvl   <= 20'h0;
      st.drv   <= 20'h0;
    end else begin
      st <= next_st;
    end
  end

  assign dat_o     = st.dat;
  assign ack_o     = st.ack;
  assign pin_lvl_o = st.lvl;
  assign pin_drv_o = st.drv;
  assign run_o     = st.start;
endmodule
`default_nettype wire

// ===== verif/tpi_checker.sv
// port assertions for the timer pin block
`timescale 1ns/1ps
`default_nettype none
module tpi_checker (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // pins
  input wire logic [19:0] match_i,
  input wire logic [19:0] pin_lvl_o,
  input wire logic [19:0] pin_drv_o,
  input wire logic [4:0]  run_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic tk;
  assign tk = cyc_i & stb_i & ~ack_o;
  a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  a_ack_on_take: assert property (tk |=> ack_o) else $error("request not acked");
  a_no_lone_ack: assert property (!tk |=> !ack_o) else $error("ack without request");
  a_reset_clear: assert property ($fell(rst_i) |->
    (pin_lvl_o == 20'h0) && (pin_drv_o == 20'h0) && (run_o == 5'h0)) else $error("reset state");
  a_unmapped_zero: assert property (tk && !we_i && adr_i >= 8'h60 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_start_bits: assert property (tk && we_i && adr_i == tpi_pkg::OFS_START && sel_i[0]
    |-> ##2 run_o == $past(dat_i[4:0], 2)) else $error("start bits wrong");
  a_moe_off: assert property (tk && we_i && adr_i == tpi_pkg::OFS_MOE && sel_i[0]
    && dat_i[1:0] == 2'h0 |-> ##2 pin_drv_o[19:12] == 8'h0) else $error("ch3/4 still driven");
  // levels move only on an io write or a compare event
  a_pins_hold: assert property (!(cyc_i && stb_i && we_i) && match_i == 20'h0
    |=> $stable(pin_lvl_o)) else $error("pin level moved");
  a_rdata_hold: assert property (!(cyc_i && stb_i) && !ack_o |=> $stable(dat_o))
    else $error("read data moved");
endmodule
bind tpi_top tpi_checker u_tpi_checker (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .match_i(match_i), .pin_lvl_o(pin_lvl_o), .pin_drv_o(pin_drv_o),
  .run_o(run_o));
`default_nettype wire

// ===== verif/tpi_pfc_model.sv
// pin function controller model: port or timer drive per pad
`timescale 1ns/1ps
`default_nettype none
module tpi_pfc_model #(
  parameter logic ACTIVE_LVL = 1'b0
) (
  input  wire logic [19:0] lvl_i,
  input  wire logic [19:0] drv_i,
  input  wire logic [19:0] port_sel_i,
  output logic      [19:0] pad_o
);
  // port drives inverse of active level; undriven pads pulled up
  always_comb begin
    for (int i = 0; i < 20; i++) begin
      pad_o[i] = port_sel_i[i] ? ~ACTIVE_LVL : (drv_i[i] ? lvl_i[i] : 1'b1);
    end
  end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the timer pin block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [19:0] match_i = 20'h0, pin_lvl_o, pin_drv_o, pad, psel = 20'h0;
  logic [4:0]  run_o;
  logic [7:0]  ma[5] = '{8'h30, 8'h40, 8'h00, 8'h10, 8'h20};
  logic [2:0]  mv[5] = '{3'h3, 3'h4, 3'h4, 3'h4, 3'h3};
  logic [2:0]  me[5] = '{3'h0, 3'h0, 3'h0, 3'h4, 3'h3};
  int          err_total = 0, n_tests = 0;
  tpi_top u_tpi_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .match_i(match_i), .pin_lvl_o(pin_lvl_o), .pin_drv_o(pin_drv_o), .run_o(run_o));
  tpi_pfc_model u_tpi_pfc_model (.lvl_i(pin_lvl_o), .drv_i(pin_drv_o), .port_sel_i(psel),
    .pad_o(pad));
  always #2 clk_i = ~clk_i;
  task automatic print_verdict();
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++t < 50);
    if (t >= 50) err_total++;
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("levels", 20'h0, pin_lvl_o)
    wb(1'b0, 8'h00, 32'h0);
    `CHK("mode", 32'h0, rd)
    wb(1'b1, 8'h04, 32'h7777);
    `CHK("ch0 init", 4'hf, pin_lvl_o[3:0])
    `CHK("ch0 drive", 4'hf, pin_drv_o[3:0])
    wb(1'b1, 8'h50, 32'h1);
    @(posedge clk_i);
    match_i <= 20'h1;
    @(posedge clk_i);
    match_i <= 20'h0;
    @(posedge clk_i);
    `CHK("match low", 4'he, pin_lvl_o[3:0])
    wb(1'b0, 8'h5c, 32'h0);
    `CHK("pin read", 32'he, rd)
    psel <= 20'hf;
    wb(1'b1, 8'h50, 32'h0);
    `CHK("port pad", 4'hf, pad[3:0])
    `CHK("stopped", 5'h0, run_o)
    wb(1'b1, 8'h04, 32'h7777);
    psel <= 20'h0;
    wb(1'b1, 8'h50, 32'h1);
    `CHK("reinit pad", 4'hf, pad[3:0])
    `CHK("restart", 5'h1, run_o)
    wb(1'b1, 8'h10, 32'h02);
    wb(1'b1, 8'h14, 32'h7777);
    `CHK("pwm_mode_one init", 4'h5, pin_lvl_o[7:4])
    wb(1'b1, 8'h10, 32'h12);
    wb(1'b1, 8'h14, 32'h1111);
    `CHK("pwm_mode_one buf", 4'h4, pin_lvl_o[7:4])
    wb(1'b1, 8'h20, 32'h23);
    wb(1'b1, 8'h24, 32'h7777);
    `CHK("pwm_mode_two init", 4'hd, pin_lvl_o[11:8])
    wb(1'b1, 8'h20, 32'h08);
    wb(1'b1, 8'h24, 32'h1111);
    `CHK("buf c", 4'h4, pin_lvl_o[11:8])
    wb(1'b1, 8'h20, 32'h00);
    wb(1'b1, 8'h24, 32'h1111);
    `CHK("unbuf", 4'h0, pin_lvl_o[11:8])
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, ma[i], {29'h0, mv[i]});
      wb(1'b0, ma[i], 32'h0);
      `CHK("mode", {29'h0, me[i]}, rd)
    end
    // pwm one blocks b and d; normal mode afterwards so they initialize too
    wb(1'b1, 8'h00, 32'h2);
    wb(1'b1, 8'h04, 32'h5555);
    `CHK("pwm_mode_one b side", 4'ha, pin_lvl_o[3:0])
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h04, 32'h5555);
    `CHK("normal init", 4'h0, pin_lvl_o[3:0])
    wb(1'b1, 8'h04, 32'h0);
    `CHK("section off", 4'h0, pin_drv_o[3:0])
    wb(1'b1, 8'h34, 32'h7777);
    `CHK("moe off", 8'h0, {pin_lvl_o[15:12], pin_drv_o[15:12]})
    wb(1'b1, 8'h54, 32'h1);
    wb(1'b1, 8'h34, 32'h7777);
    `CHK("moe on", 8'hff, {pin_lvl_o[15:12], pin_drv_o[15:12]})
    wb(1'b1, 8'h34, 32'h0);
    wb(1'b1, 8'h54, 32'h0);
    wb(1'b1, 8'h58, 32'h5a);
    wb(1'b1, 8'h30, 32'h5);
    wb(1'b1, 8'h54, 32'h3);
    wb(1'b0, 8'h58, 32'h0);
    `CHK("level ctl", 32'h5a, rd)
    wb(1'b0, 8'h30, 32'h0);
    `CHK("complementary_pwm_mode", 32'h5, rd)
    // reset-sync on ch4: level, mode, enables, restart; io writes no longer move pins
    wb(1'b1, 8'h58, 32'ha5);
    wb(1'b1, 8'h40, 32'h6);
    wb(1'b1, 8'h54, 32'h3);
    wb(1'b1, 8'h50, 32'h10);
    `CHK("reset_sync_pwm_mode run", 5'h10, run_o)
    wb(1'b0, 8'h40, 32'h0);
    `CHK("reset_sync_pwm_mode mode", 32'h6, rd)
    wb(1'b1, 8'h44, 32'h7777);
    `CHK("reset_sync_pwm_mode hold", 8'h0f, {pin_lvl_o[19:16], pin_drv_o[19:16]})
    // second reset in mid-run, with some pins, some drives and the ch4 run bit set
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("reset pins", 45'h0, {run_o, pin_lvl_o, pin_drv_o})
    wb(1'b0, 8'h40, 32'h0);
    `CHK("reset mode", 32'h0, rd)
    wb(1'b0, 8'h60, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    print_verdict();
  end
endmodule
`default_nettype wire
